// ==== verilog/dapd_pkg.sv ====
// Constants and types for the address and periodic mode command decoder.
//=============================================================================
// Overview of operation
// - Global address write: address zero, write code.
// - Accepted global write loads low data nibble.
// - Global write reply carries the new address.
// - Reply upper byte holds register at next address.
// - Reply lower byte holds address register after write.
// - Periodic entry code 1011, sixteen zero data bits.
// - Own address entry: enable, switch, reply.
// - Global address entry: enable, switch, no reply.
// - Entry for other addresses is discarded.
// - Entry reply: chip time bits, bit seven set.
// - Periodic active on enable; diagnostics need both.
// - No diagnostics: reply only to broadcast read.
// - Diagnostics: reply to broadcast read or nibble.
// - Broadcast read or non-nibble length resets accumulator.
// - Diagnostic command after eight nibbles and valid.
// - Assembled command passes the normal integrity check.
// - Broadcast read needs no check, any value.
// - Global write only while node address zero.
//=============================================================================
package dapd_pkg;

  // Frame layout of a full 32-bit command.
  localparam int          FRAME_W      = 32;
  localparam int          LEN_W        = 6;
  localparam int          ADDR_MSB     = 31;
  localparam int          ADDR_LSB     = 28;
  localparam int          CODE_MSB     = 27;
  localparam int          CODE_LSB     = 24;
  localparam int          DATA_MSB     = 23;
  localparam int          DATA_LSB     = 8;
  localparam int          CRC_W        = 8;
  localparam int          CHECKED_W    = 24;

  // Command lengths in bits.
  localparam logic [5:0]  LEN_FULL     = 6'h20;
  localparam logic [5:0]  LEN_BCAST    = 6'h01;
  localparam logic [5:0]  LEN_NIBBLE   = 6'h04;

  // Addresses and command codes.
  localparam logic [3:0]  ADDR_GLOBAL  = 4'h0;
  localparam logic [3:0]  CODE_WRITE   = 4'h8;
  localparam logic [3:0]  CODE_ENTER   = 4'hb;
  localparam logic [7:0]  REG_NODE     = 8'h11;
  localparam logic [7:0]  NODE_RESET   = 8'h00;
  localparam logic [15:0] ENTER_DATA   = 16'h0000;
  localparam logic [4:0]  ENTER_PAD_HI = 5'h00;
  localparam logic [7:0]  ENTER_LO     = 8'h80;

  // Integrity check polynomial and seed.
  localparam logic [7:0]  CRC_POLY     = 8'h2f;
  localparam logic [7:0]  CRC_SEED     = 8'hff;

  // Diagnostic fragment gathering.
  localparam int          NIB_W        = 4;
  localparam logic [2:0]  NIB_LAST     = 3'h7;
  localparam logic [2:0]  NIB_ZERO     = 3'h0;

  // Operating modes, one-hot.
  typedef enum logic [1:0] {
    DAPD_CMD_RESP = 2'b01,
    DAPD_PERIODIC = 2'b10
  } dapd_mode_t;

endpackage

// ==== verilog/dapd_decoder.sv ====
// Command decoder for address assignment and periodic collection mode.
module dapd_decoder
  import dapd_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               sys_rst_i,
  // Received command from the symbol decoder
  input  wire logic               cmd_valid_i,
  input  wire logic [LEN_W-1:0]   cmd_len_i,
  input  wire logic [FRAME_W-1:0] cmd_data_i,
  // Settings held elsewhere in the device
  input  wire logic               diag_mode_enable_i,
  input  wire logic [2:0]         chip_time_bits_i,
  input  wire logic [7:0]         next_reg_byte_i,
  // Command and response replies
  output logic                    reply_valid_o,
  output logic [23:0]             reply_frame_o,
  // Periodic replies and assembled diagnostic commands
  output logic                    periodic_reply_o,
  output logic                    diag_cmd_valid_o,
  output logic [FRAME_W-1:0]      diag_cmd_o,
  // State
  output logic                    periodic_mode_enable_o,
  output logic                    background_diag_mode_o,
  output logic [7:0]              node_physical_address_o
);

  //===========================================================================
  // Integrity check
  function automatic logic [7:0] crc_of(input logic [FRAME_W-1:0] f);
    logic [7:0] c;
    logic       fb;
    c  = CRC_SEED;
    fb = 1'b0;
    for (int i = FRAME_W - 1; i >= CRC_W; i--)
    begin
      fb = c[7] ^ f[i];
      c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  //===========================================================================
  // Frame field decode
  logic [3:0]       f_addr;
  logic [3:0]       f_code;
  logic [15:0]      f_data;
  logic             f_crc_ok;
  logic             full_frame;
  logic             mode_cr;
  logic             mode_pd;
  logic             glob_write;
  logic             enter_own;
  logic             enter_glob;
  logic             nibble;
  logic             bcast;
  logic             diag_on;
  logic [FRAME_W-1:0] assembled;
  logic             asm_crc_ok;
  dapd_mode_t       mode_reg;
  logic [7:0]       node_reg;
  logic [2:0]       nib_cnt_reg;
  logic [FRAME_W-1:0] nib_acc_reg;

  assign f_addr     = cmd_data_i[ADDR_MSB:ADDR_LSB];
  assign f_code     = cmd_data_i[CODE_MSB:CODE_LSB];
  assign f_data     = cmd_data_i[DATA_MSB:DATA_LSB];
  assign f_crc_ok   = (crc_of(cmd_data_i) == cmd_data_i[CRC_W-1:0]);
  assign full_frame = cmd_valid_i && (cmd_len_i == LEN_FULL)
                      && f_crc_ok;
  assign mode_cr    = (mode_reg == DAPD_CMD_RESP);
  assign mode_pd    = (mode_reg == DAPD_PERIODIC);

  assign glob_write = full_frame && mode_cr
                      && (f_addr == ADDR_GLOBAL)
                      && (f_code == CODE_WRITE)
                      && (f_data[15:8] == REG_NODE)
                      && (node_reg[3:0] == ADDR_GLOBAL);

  assign enter_own  = full_frame && mode_cr
                      && (f_code == CODE_ENTER) && (f_data == ENTER_DATA)
                      && (f_addr == node_reg[3:0])
                      && (f_addr != ADDR_GLOBAL);
  assign enter_glob = full_frame && mode_cr
                      && (f_code == CODE_ENTER) && (f_data == ENTER_DATA)
                      && (f_addr == ADDR_GLOBAL);

  assign diag_on    = mode_pd && diag_mode_enable_i;
  assign bcast      = cmd_valid_i && mode_pd
                      && (cmd_len_i == LEN_BCAST);
  assign nibble     = cmd_valid_i && diag_on && (cmd_len_i == LEN_NIBBLE);
  assign assembled  = {nib_acc_reg[FRAME_W-NIB_W-1:0],
                       cmd_data_i[NIB_W-1:0]};
  assign asm_crc_ok = (crc_of(assembled) == assembled[CRC_W-1:0]);

  //===========================================================================
  // Operating mode
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      mode_reg <= DAPD_CMD_RESP;
    else if (enter_own || enter_glob)
      mode_reg <= DAPD_PERIODIC;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      periodic_mode_enable_o <= 1'b0;
      background_diag_mode_o <= 1'b0;
    end
    else
    begin
      periodic_mode_enable_o <= mode_pd || enter_own || enter_glob;
      background_diag_mode_o <= diag_on;
    end
  end

  //===========================================================================
  // Node address register
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      node_reg <= NODE_RESET;
    else if (glob_write)
      node_reg <= {4'h0, f_data[3:0]};
  end

  assign node_physical_address_o = node_reg;

  //===========================================================================
  // Command and response replies
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      reply_valid_o <= 1'b0;
      reply_frame_o <= 24'h000000;
    end
    else
    begin
      reply_valid_o <= glob_write || enter_own;
      if (glob_write)
        reply_frame_o <= {f_data[3:0], CODE_WRITE,
                          next_reg_byte_i,
                          4'h0, f_data[3:0]};
      else if (enter_own)
        reply_frame_o <= {node_reg[3:0], CODE_ENTER,
                          ENTER_PAD_HI, chip_time_bits_i,
                          ENTER_LO};
    end
  end

  //===========================================================================
  // Diagnostic fragment accumulator
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || !diag_on)
    begin
      nib_cnt_reg <= NIB_ZERO;
      nib_acc_reg <= '0;
    end
    else if (nibble)
    begin
      nib_cnt_reg <= nib_cnt_reg + 3'h1;
      nib_acc_reg <= assembled;
    end
    else if (cmd_valid_i)
    begin
      nib_cnt_reg <= NIB_ZERO;
      nib_acc_reg <= '0;
    end
  end

  //===========================================================================
  // Periodic and diagnostic replies
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      periodic_reply_o <= 1'b0;
      diag_cmd_valid_o <= 1'b0;
      diag_cmd_o       <= '0;
    end
    else
    begin
      periodic_reply_o <= bcast || nibble;
      diag_cmd_valid_o <= nibble && (nib_cnt_reg == NIB_LAST)
                          && asm_crc_ok;
      if (nibble && (nib_cnt_reg == NIB_LAST))
        diag_cmd_o <= assembled;
    end
  end

  //===========================================================================
  // Checks
  addr_write_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    glob_write |=> node_reg == {4'h0, $past(f_data[3:0])})
    else $error("Address write did not load new address.");

  addr_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (node_reg[3:0] != ADDR_GLOBAL) |=> $stable(node_reg))
    else $error("Node address changed after assignment.");

  write_reply_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    glob_write |=> reply_valid_o
      && reply_frame_o[23:20] == node_reg[3:0]
      && reply_frame_o[7:0] == node_reg)
    else $error("Address write reply is wrong.");

  next_byte_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    glob_write |=> reply_frame_o[15:8] == $past(next_reg_byte_i))
    else $error("Reply upper byte is not the next register.");

  enter_reply_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    enter_own |=> reply_valid_o && periodic_mode_enable_o
      && reply_frame_o[15:0] == {5'h00, $past(chip_time_bits_i), 8'h80})
    else $error("Addressed entry reply is wrong.");

  global_quiet_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    enter_glob |=> !reply_valid_o && periodic_mode_enable_o)
    else $error("Global entry answered or failed to switch.");

  other_addr_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_valid_i && !periodic_mode_enable_o
      && cmd_data_i[CODE_MSB:CODE_LSB] == CODE_ENTER
      && cmd_data_i[ADDR_MSB:ADDR_LSB] != ADDR_GLOBAL
      && cmd_data_i[ADDR_MSB:ADDR_LSB] != node_physical_address_o[3:0])
      |=> !reply_valid_o && !periodic_mode_enable_o)
    else $error("Entry for another node had an effect.");

  bad_frame_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_len_i == LEN_FULL && !f_crc_ok)
      |=> !reply_valid_o && $stable(node_reg)
        && $stable(periodic_mode_enable_o))
    else $error("Frame with failed check had an effect.");

  mode_stay_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    periodic_mode_enable_o |=> periodic_mode_enable_o)
    else $error("Periodic mode left without reset.");

  diag_gate_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    background_diag_mode_o |-> periodic_mode_enable_o)
    else $error("Diagnostic mode active outside periodic mode.");

  bcast_reply_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_len_i == LEN_BCAST && periodic_mode_enable_o)
      |=> periodic_reply_o)
    else $error("Broadcast read got no periodic reply.");

  nib_reply_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_len_i == LEN_NIBBLE && periodic_mode_enable_o
      && diag_mode_enable_i) |=> periodic_reply_o)
    else $error("Fragment got no periodic reply.");

  nib_quiet_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_len_i == LEN_NIBBLE && !diag_mode_enable_i)
      |=> !periodic_reply_o)
    else $error("Fragment answered with diagnostics off.");

  pd_frame_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_len_i == LEN_FULL && periodic_mode_enable_o)
      |=> !reply_valid_o && !periodic_reply_o)
    else $error("Full frame answered in periodic mode.");

  pd_reply_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    periodic_reply_o |-> $past(mode_pd) && $past(cmd_valid_i)
      && ($past(cmd_len_i) == LEN_BCAST
        || ($past(cmd_len_i) == LEN_NIBBLE && $past(diag_on))))
    else $error("Periodic reply without a qualifying command.");

  acc_reset_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_len_i != LEN_NIBBLE) |=> nib_cnt_reg == NIB_ZERO)
    else $error("Accumulator not reset.");

  diag_eight_a: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    diag_cmd_valid_o |-> $past(nib_cnt_reg) == NIB_LAST
      && crc_of(diag_cmd_o) == diag_cmd_o[7:0])
    else $error("Diagnostic command without eight valid nibbles.");

  cov_glob_write_c: cover property (@(posedge clk_sys_i) glob_write);
  cov_enter_own_c: cover property (@(posedge clk_sys_i) enter_own);
  cov_enter_glob_c: cover property (@(posedge clk_sys_i) enter_glob);
  cov_diag_c: cover property (@(posedge clk_sys_i) diag_cmd_valid_o);
  cov_bcast_c: cover property (@(posedge clk_sys_i) bcast && !diag_on);

endmodule

// ==== test/dapd_master.sv ====
// Bus master model that frames commands and sends them to the decoder.
module dapd_master
  import dapd_pkg::*;
(
  // Clock
  input  wire logic          clk_sys_i,
  // Command port
  output logic               cmd_valid_o,
  output logic [LEN_W-1:0]   cmd_len_o,
  output logic [FRAME_W-1:0] cmd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_len_o   = 6'h00;
    cmd_data_o  = 32'h0000_0000;
  end

  //===========================================================================
  // Integrity check over the checked part of a frame, MSB first.
  function automatic logic [7:0] crc8(input logic [23:0] m);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ (((c[7] ^ m[i]) == 1'b1) ? CRC_POLY : 8'h00);
    return c;
  endfunction

  //===========================================================================
  // Sends one command; released data lines show the inverted last value.
  task automatic send(input logic [5:0] len, input logic [31:0] dat);
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b1;
    cmd_len_o   <= len;
    cmd_data_o  <= dat;
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b0;
    cmd_data_o  <= ~dat;
  endtask

  // Sends a full frame, the check byte spoilt when bad is set.
  task automatic frame(input logic [3:0] a, input logic [3:0] c,
                       input logic [15:0] d, input logic bad);
    send(LEN_FULL, {a, c, d, crc8({a, c, d}) ^ {7'h00, bad}});
  endtask

  // Sends the first n nibbles of a frame, most significant first.
  task automatic nibbles(input logic [31:0] f, input int n);
    for (int i = 0; i < n; i++)
      send(LEN_NIBBLE, {28'h0, f[31-4*i -: 4]});
  endtask
endmodule

// ==== test/dapd_decoder_test.sv ====
// Self-checking testbench for the address and periodic mode decoder.
module dapd_decoder_test
  import dapd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cmd_valid, diag_en = 1'b0, rep_v, per_v, dg_v, pme, background_diag_mode;
  logic [5:0] cmd_len;
  logic [31:0] cmd_data, dg_cmd, g;
  logic [23:0] rep_f;
  logic [7:0] node;
  logic [2:0] chip_t = 3'h6;
  logic [7:0] next_b = 8'h3a;
  int fail_count = 0, samples_checked = 0, n_rep = 0, n_per = 0, n_dg = 0;
  int b_rep = 0, b_per = 0, b_dg = 0;

  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  dapd_master u_master (.clk_sys_i(clk_sys_i), .cmd_valid_o(cmd_valid),
    .cmd_len_o(cmd_len), .cmd_data_o(cmd_data));

  dapd_decoder u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid), .cmd_len_i(cmd_len), .cmd_data_i(cmd_data),
    .diag_mode_enable_i(diag_en), .chip_time_bits_i(chip_t),
    .next_reg_byte_i(next_b), .reply_valid_o(rep_v), .reply_frame_o(rep_f),
    .periodic_reply_o(per_v), .diag_cmd_valid_o(dg_v), .diag_cmd_o(dg_cmd),
    .periodic_mode_enable_o(pme), .background_diag_mode_o(background_diag_mode),
    .node_physical_address_o(node));

  //===========================================================================
  // Pulse counters.
  always @(posedge clk_sys_i)
  begin
    n_rep <= n_rep + int'(rep_v === 1'b1);
    n_per <= n_per + int'(per_v === 1'b1);
    n_dg  <= n_dg + int'(dg_v === 1'b1);
  end

  //===========================================================================
  // Checking and reporting.
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Lets the answer land and compares the pulses seen since the last call.
  task automatic sent(input int r, input int p, input int d);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("replies", r, n_rep - b_rep);
    chk("periodic replies", p, n_per - b_per);
    chk("diag commands", d, n_dg - b_dg);
    b_rep = n_rep;
    b_per = n_per;
    b_dg  = n_dg;
  endtask

  task automatic reset_dut();
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (7) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    sent(0, 0, 0);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  //===========================================================================
  // Main sequence.
  initial
  begin
    reset_dut();
    chk("node", 32'h0, node);
    chk("mode", 32'h0, pme);
    u_master.send(LEN_BCAST, 32'h1);
    sent(0, 0, 0);
    u_master.frame(4'h0, CODE_WRITE, 16'h1105, 1'b1);
    sent(0, 0, 0);
    chk("node", 32'h0, node);
    u_master.frame(4'h0, CODE_WRITE, 16'h1105, 1'b0);
    sent(1, 0, 0);
    chk("node", 32'h05, node);
    chk("frame", 32'h58_3a05, rep_f);
    u_master.frame(4'h0, CODE_WRITE, 16'h1109, 1'b0);
    sent(0, 0, 0);
    chk("node", 32'h05, node);
    u_master.frame(4'h3, CODE_ENTER, 16'h0000, 1'b0);
    u_master.frame(4'h5, CODE_ENTER, 16'h0001, 1'b0);
    sent(0, 0, 0);
    chk("mode", 32'h0, pme);
    u_master.frame(4'h5, CODE_ENTER, 16'h0000, 1'b0);
    sent(1, 0, 0);
    chk("mode", 32'h1, pme);
    chk("frame", 32'h5b_0680, rep_f);
    chk("diag mode", 32'h0, background_diag_mode);
    u_master.frame(4'h5, CODE_ENTER, 16'h0000, 1'b0);
    u_master.send(LEN_BCAST, 32'h1);
    u_master.send(LEN_BCAST, 32'h0);
    u_master.send(LEN_NIBBLE, 32'ha);
    sent(0, 2, 0);
    @(posedge clk_sys_i);
    diag_en <= 1'b1;
    sent(0, 0, 0);
    chk("diag mode", 32'h1, background_diag_mode);
    g = {24'h501100, u_master.crc8(24'h501100)};
    u_master.nibbles(g, 5);
    u_master.send(6'h02, 32'h3);
    u_master.nibbles(g, 8);
    sent(0, 13, 1);
    chk("diag cmd", g, dg_cmd);
    u_master.nibbles(g, 3);
    u_master.send(LEN_BCAST, 32'h0);
    u_master.nibbles(g, 8);
    sent(0, 12, 1);
    u_master.nibbles(g ^ 32'h1, 8);
    sent(0, 8, 0);
    reset_dut();
    chk("node", 32'h0, node);
    chk("diag mode", 32'h0, background_diag_mode);
    u_master.frame(4'h0, CODE_ENTER, 16'h0000, 1'b0);
    sent(0, 0, 0);
    chk("mode", 32'h1, pme);
    chk("diag mode", 32'h1, background_diag_mode);
    conclude();
  end
endmodule
